//--- pkg/ccr_pkg.sv
package ccr_pkg;
   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [11:0] IDX_POWER_CONTROL = 12'h015;
   localparam logic [11:0] IDX_OUTPUT_SWING = 12'h025;
   localparam logic [11:0] IDX_CLOCK_DIVIDER = 12'h027;
   localparam logic [11:0] IDX_HD3_MODE_BIT0 = 12'h41d;
   localparam logic [11:0] IDX_CHOPPER_CHAN_A = 12'h422;
   localparam logic [11:0] IDX_DITHER_CHAN_A = 12'h434;
   localparam logic [11:0] IDX_SPECIAL_MODE_CHAN_A = 12'h439;
   localparam logic [11:0] IDX_HD3_MODE_BIT1 = 12'h51d;
   localparam logic [11:0] IDX_CHOPPER_CHAN_B = 12'h522;
   localparam logic [11:0] IDX_DITHER_CHAN_B = 12'h534;
   localparam logic [11:0] IDX_SPECIAL_MODE_CHAN_B = 12'h539;
   localparam logic [11:0] IDX_HD3_MODE_UPPER = 12'h608;
   localparam logic [11:0] IDX_CLOCK_FILTER_SYNC = 12'h70a;
   localparam logic [11:0] IDX_DITHER_COMPANION = 12'h001;

   // ----------------------------------------
   // Writable-bit masks per register
   // ----------------------------------------
   localparam logic [7:0] MASK_POWER_CONTROL = 8'h6d;
   localparam logic [7:0] MASK_OUTPUT_SWING = 8'hff;
   localparam logic [7:0] MASK_CLOCK_DIVIDER = 8'hc0;
   localparam logic [7:0] MASK_BIT1 = 8'h02;
   localparam logic [7:0] MASK_DITHER = 8'h28;
   localparam logic [7:0] MASK_BIT3 = 8'h08;
   localparam logic [7:0] MASK_HD3_UPPER = 8'hc0;
   localparam logic [7:0] MASK_CLOCK_FILTER_SYNC = 8'h81;
   localparam logic [7:0] MASK_DITHER_COMPANION = 8'h3c;
   localparam logic [7:0] RESET_VALUE = 8'h00;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int POS_CHAN_A_PDN = 6;
   localparam int POS_CHAN_B_PDN = 5;
   localparam int POS_STANDBY = 3;
   localparam int POS_WHOLE_DEVICE_POWERDOWN = 2;
   localparam int POS_PIN_SELECT = 0;
   localparam int POS_CHOP = 1;
   localparam int POS_DITH_HI = 5;
   localparam int POS_DITH_LO = 3;
   localparam int POS_PERF = 3;
   localparam int POS_HD3_BIT = 1;
   localparam int POS_FILT_BYPASS = 7;
   localparam int POS_SYNC_OFF = 0;
   localparam int POS_COMP_A = 4;
   localparam int POS_COMP_B = 2;

   // ----------------------------------------
   // Swing codes and divider codes
   // ----------------------------------------
   localparam logic [3:0] SWING_DEFAULT = 4'h0;
   localparam logic [3:0] SWING_M50 = 4'h9;
   localparam logic [3:0] SWING_M100 = 4'ha;
   localparam logic [3:0] SWING_M300 = 4'hd;
   localparam logic [3:0] SWING_P100 = 4'he;
   localparam logic [1:0] DIV_BY2 = 2'h2;
   localparam logic [1:0] DIV_BY4 = 2'h3;

   typedef enum logic [2:0] {
      CCR_SW_DEFAULT = 3'h0,
      CCR_SW_M50 = 3'h1,
      CCR_SW_M100 = 3'h2,
      CCR_SW_M300 = 3'h3,
      CCR_SW_P100 = 3'h4,
      CCR_SW_ILLEGAL = 3'h7
   } ccr_swing_e;

   // Analog control outputs
   typedef struct packed {
      logic chan_a_off;
      logic chan_b_off;
      logic standby;
      logic whole_device_powerdown;
      ccr_swing_e swing_sel;
      logic [2:0] clk_div_ratio;
      logic [3:0] hd3_boost_mode;
      logic chan_a_chopper_off;
      logic chan_b_chopper_off;
      logic dither_a_off;
      logic dither_b_off;
      logic chan_a_perf_special;
      logic chan_b_perf_special;
      logic sync_ref_buffer_off;
      logic clock_filter_bypass;
   } ccr_ctrl_s;

   // Complete register state
   typedef struct packed {
      logic [7:0] power_control;
      logic [7:0] output_swing;
      logic [7:0] clock_divider;
      logic [7:0] hd3_bit0;
      logic [7:0] chop_a;
      logic [7:0] dith_a;
      logic [7:0] spec_a;
      logic [7:0] hd3_bit1;
      logic [7:0] chop_b;
      logic [7:0] dith_b;
      logic [7:0] spec_b;
      logic [7:0] hd3_upper;
      logic [7:0] filt_sync;
      logic [7:0] dith_comp;
      logic pin_meta;
      logic pin_sync;
      logic ack;
      logic [31:0] rdata;
      ccr_ctrl_s ctrl;
   } ccr_state_s;
endpackage : ccr_pkg

//--- core/ccr_regs.sv
module ccr_regs #(
   // Bus widths; the decode below serves only these values
   parameter int ADR_W = 14,
   parameter int DAT_W = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   output logic [DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Device pin
   input wire logic powerdown_pin,
   // Analog controls
   output ccr_pkg::ccr_ctrl_s ctrl_o,
   output logic swing_code_illegal
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   // Twelve index bits above the byte lanes, one 32-bit data word
   if (ADR_W != 14) begin : g_bad_adr
      $error("ccr_regs: address width must be 14");
   end
   if (DAT_W != 32) begin : g_bad_dat
      $error("ccr_regs: data width must be 32");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   ccr_pkg::ccr_state_s s_q;
   ccr_pkg::ccr_state_s s_d;
   logic req;
   logic hit;
   logic wr;
   logic [11:0] idx;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic pin_pd;
   logic pin_sb;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // Request taken once; the pending ack blocks a second take
   assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
   // Full index compared, byte lanes ignored
   assign idx = wb_adr_i[ADR_W-1:2];
   assign wbyte = wb_dat_i[7:0];

   // Masked merge of a write into one register
   function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] mask,
                                      input logic sel);
      upd = sel ? (wbyte & mask) : old;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      hit = 1'b1;
      rbyte = ccr_pkg::RESET_VALUE;
      wr = req && wb_we_i && wb_sel_i[0];
      s_d.ack = 1'b0;
      // Pin synchroniser
      s_d.pin_meta = powerdown_pin;
      s_d.pin_sync = s_q.pin_meta;
      // Register decode, reads and writes; reserved bits masked to zero
      unique case (idx)

         // Channel and whole-device power, pin function select
         ccr_pkg::IDX_POWER_CONTROL: begin
            rbyte = s_q.power_control;
            s_d.power_control = upd(s_q.power_control,
                                    ccr_pkg::MASK_POWER_CONTROL, wr);
         end

         // Serial output swing, full byte kept, low nibble decoded
         ccr_pkg::IDX_OUTPUT_SWING: begin
            rbyte = s_q.output_swing;
            s_d.output_swing = upd(s_q.output_swing,
                                   ccr_pkg::MASK_OUTPUT_SWING, wr);
         end

         // Sampling clock divider in the top two bits
         ccr_pkg::IDX_CLOCK_DIVIDER: begin
            rbyte = s_q.clock_divider;
            s_d.clock_divider = upd(s_q.clock_divider,
                                    ccr_pkg::MASK_CLOCK_DIVIDER, wr);
         end

         // Distortion mode, lowest bit
         ccr_pkg::IDX_HD3_MODE_BIT0: begin
            rbyte = s_q.hd3_bit0;
            s_d.hd3_bit0 = upd(s_q.hd3_bit0,
                               ccr_pkg::MASK_BIT1, wr);
         end

         // Channel A chopper disable
         ccr_pkg::IDX_CHOPPER_CHAN_A: begin
            rbyte = s_q.chop_a;
            s_d.chop_a = upd(s_q.chop_a,
                             ccr_pkg::MASK_BIT1, wr);
         end

         // Channel A dither disable pair
         ccr_pkg::IDX_DITHER_CHAN_A: begin
            rbyte = s_q.dith_a;
            s_d.dith_a = upd(s_q.dith_a,
                             ccr_pkg::MASK_DITHER, wr);
         end

         // Channel A special performance bit
         ccr_pkg::IDX_SPECIAL_MODE_CHAN_A: begin
            rbyte = s_q.spec_a;
            s_d.spec_a = upd(s_q.spec_a,
                             ccr_pkg::MASK_BIT3, wr);
         end

         // Distortion mode, second bit
         ccr_pkg::IDX_HD3_MODE_BIT1: begin
            rbyte = s_q.hd3_bit1;
            s_d.hd3_bit1 = upd(s_q.hd3_bit1,
                               ccr_pkg::MASK_BIT1, wr);
         end

         // Channel B chopper disable
         ccr_pkg::IDX_CHOPPER_CHAN_B: begin
            rbyte = s_q.chop_b;
            s_d.chop_b = upd(s_q.chop_b,
                             ccr_pkg::MASK_BIT1, wr);
         end

         // Channel B dither disable pair
         ccr_pkg::IDX_DITHER_CHAN_B: begin
            rbyte = s_q.dith_b;
            s_d.dith_b = upd(s_q.dith_b,
                             ccr_pkg::MASK_DITHER, wr);
         end

         // Channel B special performance bit
         ccr_pkg::IDX_SPECIAL_MODE_CHAN_B: begin
            rbyte = s_q.spec_b;
            s_d.spec_b = upd(s_q.spec_b,
                             ccr_pkg::MASK_BIT3, wr);
         end

         // Distortion mode, upper two bits
         ccr_pkg::IDX_HD3_MODE_UPPER: begin
            rbyte = s_q.hd3_upper;
            s_d.hd3_upper = upd(s_q.hd3_upper,
                                ccr_pkg::MASK_HD3_UPPER, wr);
         end

         // Clock filter bypass and sync buffer power-down
         ccr_pkg::IDX_CLOCK_FILTER_SYNC: begin
            rbyte = s_q.filt_sync;
            s_d.filt_sync = upd(s_q.filt_sync,
                                ccr_pkg::MASK_CLOCK_FILTER_SYNC, wr);
         end

         // Companion dither pairs for both channels
         ccr_pkg::IDX_DITHER_COMPANION: begin
            rbyte = s_q.dith_comp;
            s_d.dith_comp = upd(s_q.dith_comp,
                                ccr_pkg::MASK_DITHER_COMPANION, wr);
         end

         // Unmapped index: no write, reads zero, error answer
         default: begin
            hit = 1'b0;
         end
      endcase

      // Answer: ack for mapped, err for unmapped
      if (req) begin
         s_d.ack = 1'b1;
         s_d.rdata = {24'h000000, rbyte};
      end

      // Power-down pin effect selected by config bit
      pin_pd = s_q.pin_sync && !s_q.power_control[ccr_pkg::POS_PIN_SELECT];
      pin_sb = s_q.pin_sync && s_q.power_control[ccr_pkg::POS_PIN_SELECT];

      // Power controls
      s_d.ctrl.chan_a_off = s_q.power_control[ccr_pkg::POS_CHAN_A_PDN];
      s_d.ctrl.chan_b_off = s_q.power_control[ccr_pkg::POS_CHAN_B_PDN];
      s_d.ctrl.standby = s_q.power_control[ccr_pkg::POS_STANDBY] || pin_sb;
      s_d.ctrl.whole_device_powerdown = s_q.power_control[ccr_pkg::POS_WHOLE_DEVICE_POWERDOWN] || pin_pd;

      // Swing decode on low nibble only
      unique case (s_q.output_swing[3:0])
         ccr_pkg::SWING_DEFAULT: s_d.ctrl.swing_sel = ccr_pkg::CCR_SW_DEFAULT;
         ccr_pkg::SWING_M50: s_d.ctrl.swing_sel = ccr_pkg::CCR_SW_M50;
         ccr_pkg::SWING_M100: s_d.ctrl.swing_sel = ccr_pkg::CCR_SW_M100;
         ccr_pkg::SWING_M300: s_d.ctrl.swing_sel = ccr_pkg::CCR_SW_M300;
         ccr_pkg::SWING_P100: s_d.ctrl.swing_sel = ccr_pkg::CCR_SW_P100;
         default: s_d.ctrl.swing_sel = ccr_pkg::CCR_SW_ILLEGAL;
      endcase

      // Clock divide ratio, one-hot 1/2/4
      unique case (s_q.clock_divider[7:6])
         ccr_pkg::DIV_BY2: s_d.ctrl.clk_div_ratio = 3'h2;
         ccr_pkg::DIV_BY4: s_d.ctrl.clk_div_ratio = 3'h4;
         default: s_d.ctrl.clk_div_ratio = 3'h1;
      endcase

      // Distortion mode gathered from three registers
      s_d.ctrl.hd3_boost_mode = {s_q.hd3_upper[7:6], s_q.hd3_bit1[ccr_pkg::POS_HD3_BIT],
                                 s_q.hd3_bit0[ccr_pkg::POS_HD3_BIT]};

      // Chopper, dither, special mode, sync and filter
      s_d.ctrl.chan_a_chopper_off = s_q.chop_a[ccr_pkg::POS_CHOP];
      s_d.ctrl.chan_b_chopper_off = s_q.chop_b[ccr_pkg::POS_CHOP];
      s_d.ctrl.dither_a_off = s_q.dith_a[ccr_pkg::POS_DITH_HI] && s_q.dith_a[ccr_pkg::POS_DITH_LO]
         && (s_q.dith_comp[ccr_pkg::POS_COMP_A +: 2] == 2'h3);
      s_d.ctrl.dither_b_off = s_q.dith_b[ccr_pkg::POS_DITH_HI] && s_q.dith_b[ccr_pkg::POS_DITH_LO]
         && (s_q.dith_comp[ccr_pkg::POS_COMP_B +: 2] == 2'h3);
      s_d.ctrl.chan_a_perf_special = s_q.spec_a[ccr_pkg::POS_PERF];
      s_d.ctrl.chan_b_perf_special = s_q.spec_b[ccr_pkg::POS_PERF];
      s_d.ctrl.sync_ref_buffer_off = s_q.filt_sync[ccr_pkg::POS_SYNC_OFF];
      s_d.ctrl.clock_filter_bypass = s_q.filt_sync[ccr_pkg::POS_FILT_BYPASS];
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Synchronous reset clears everything
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Error flag kept beside the state for the unmapped answer
   logic err_q;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         err_q <= 1'b0;
      end else begin
         err_q <= req && !hit;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Bus answer split by the error flag
   assign wb_ack_o = s_q.ack && !err_q;
   assign wb_err_o = s_q.ack && err_q;
   assign wb_dat_o = s_q.rdata;
   assign ctrl_o = s_q.ctrl;
   assign swing_code_illegal = (s_q.ctrl.swing_sel == ccr_pkg::CCR_SW_ILLEGAL);

endmodule // ccr_regs

//--- tb/ccr_regs_props.sv
module ccr_regs_props (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [13:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // Pin and controls
   input wire logic powerdown_pin,
   input wire ccr_pkg::ccr_ctrl_s ctrl_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Request seen this edge, and write taken this edge
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire take = req && wb_we_i && wb_sel_i[0];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Written field lands on its control two edges later
   property p_wr(idx, b, f);
      take && wb_adr_i[13:2] == idx |-> ##2 f == $past(wb_dat_i[b], 2);
   endproperty
   a_chan_a_off: assert property (p_wr(12'h015, 6, ctrl_o.chan_a_off))
      else $error("channel a power-down wrong");
   a_chan_b_off: assert property (p_wr(12'h015, 5, ctrl_o.chan_b_off))
      else $error("channel b power-down wrong");
   a_chop_a_off: assert property (p_wr(12'h422, 1, ctrl_o.chan_a_chopper_off))
      else $error("channel a chopper wrong");
   a_sync_buf_off: assert property (p_wr(12'h70a, 0, ctrl_o.sync_ref_buffer_off))
      else $error("sync buffer control wrong");
   a_filt_bypass: assert property (p_wr(12'h70a, 7, ctrl_o.clock_filter_bypass))
      else $error("filter bypass wrong");
   a_clk_div: assert property (take && wb_adr_i[13:2] == 12'h027 |-> ##2
      ctrl_o.clk_div_ratio == ($past(wb_dat_i[7:6], 2) == 2'h3 ? 3'h4 :
      $past(wb_dat_i[7], 2) ? 3'h2 : 3'h1))
      else $error("divider ratio wrong");
   a_pin_effect: assert property (powerdown_pin [*4] |-> ctrl_o.standby || ctrl_o.whole_device_powerdown)
      else $error("pin had no effect");
   a_unmapped_err: assert property (req && wb_adr_i[13:2] == 12'h01d |=> wb_err_o && !wb_ack_o)
      else $error("unmapped index answered");
   a_answer_time: assert property (req |=> wb_ack_o ^ wb_err_o)
      else $error("no single answer after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o)
      else $error("ack longer than one cycle");
   // Main scenarios
   c_write: cover property (take);
   c_error: cover property (wb_err_o);
   c_pin: cover property (powerdown_pin [*4]);
endmodule // ccr_regs_props

bind ccr_regs ccr_regs_props u_props (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o, .powerdown_pin, .ctrl_o);

//--- tb/ccr_host.sv
module ccr_host (
   // Clock
   input wire logic core_clk,
   // Wishbone master
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [13:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i,
   input wire logic wb_err_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus at time zero
   initial begin
      {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
   end
   // One classic cycle, held until ack or err
   task automatic xfer(input logic w, input logic [11:0] idx, input logic [7:0] d,
      output logic [31:0] q, output logic e);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= w;
      wb_sel_o <= 4'h1;
      wb_adr_o <= {idx, 2'h0};
      wb_dat_o <= {24'h0, d};
      do @(posedge core_clk); while (!(wb_ack_i || wb_err_i));
      q = wb_dat_i;
      e = wb_err_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_adr_o <= ~wb_adr_o;
      wb_dat_o <= ~wb_dat_o;
      @(posedge core_clk);
   endtask
   // Start-up writes, issued once by t_misc
   task automatic init();
      logic [31:0] q;
      logic e;
      xfer(1'b1, 12'h439, 8'h08, q, e);
      xfer(1'b1, 12'h539, 8'h08, q, e);
      xfer(1'b1, 12'h70a, 8'h01, q, e);
   endtask
endmodule // ccr_host

//--- tb/tb_converter_config_registers.sv
module tb_converter_config_registers;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic powerdown_pin = 1'b0;
   logic cyc, stb, we, ack, err, illegal;
   logic [13:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r;
   ccr_pkg::ccr_ctrl_s ctrl;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   localparam logic [11:0] IDX [13] = '{12'h015, 12'h025, 12'h027, 12'h41d, 12'h422,
      12'h434, 12'h439, 12'h51d, 12'h522, 12'h534, 12'h539, 12'h608, 12'h70a};
   localparam logic [7:0] MSK [13] = '{8'h6d, 8'hff, 8'hc0, 8'h02, 8'h02, 8'h28, 8'h08,
      8'h02, 8'h02, 8'h28, 8'h08, 8'hc0, 8'h81};
   always #25 core_clk = ~core_clk;
   ccr_regs u_dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .wb_err_o(err), .powerdown_pin(powerdown_pin), .ctrl_o(ctrl),
      .swing_code_illegal(illegal));
   ccr_host u_host (.core_clk(core_clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
      .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat_w), .wb_dat_i(dat_r), .wb_ack_i(ack),
      .wb_err_i(err));
   // ----------------------------------------
   // Report and compare
   // ----------------------------------------
   task automatic end_sim();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bad(input string m);
      failures++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) bad($sformatf("read %h not %h", got, exp));
   endtask
   task automatic chk_ctl(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) bad($sformatf("control %h not %h", got, exp));
   endtask
   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b1, i, d, q, e);
   endtask
   task automatic rdc(input logic [11:0] i, input logic [7:0] x);
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b0, i, 8'h00, q, e);
      chk_rd(q, {24'h0, x});
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_bank();
      foreach (IDX[i]) rdc(IDX[i], 8'h00);
      chk_ctl({5'h0, ctrl.clk_div_ratio}, 8'h01);
      foreach (IDX[i]) wr(IDX[i], 8'hff);
      foreach (IDX[i]) rdc(IDX[i], MSK[i]);
      chk_ctl({ctrl.chan_a_off, ctrl.chan_b_off, ctrl.standby, ctrl.whole_device_powerdown,
         ctrl.hd3_boost_mode}, 8'hff);
      chk_ctl({ctrl.chan_a_chopper_off, ctrl.chan_b_chopper_off, ctrl.chan_a_perf_special,
         ctrl.chan_b_perf_special, ctrl.sync_ref_buffer_off, ctrl.clock_filter_bypass,
         ctrl.dither_a_off, ctrl.dither_b_off}, 8'hfc);
      chk_ctl({4'h0, illegal, ctrl.clk_div_ratio}, 8'h0c);
      wr(12'h001, 8'h3c);
      chk_ctl({6'h0, ctrl.dither_a_off, ctrl.dither_b_off}, 8'h03);
      wr(12'h434, 8'h20);
      chk_ctl({6'h0, ctrl.dither_a_off, ctrl.dither_b_off}, 8'h01);
      foreach (IDX[i]) wr(IDX[i], 8'h00);
      chk_ctl({ctrl.chan_a_off, ctrl.chan_b_off, ctrl.standby, ctrl.whole_device_powerdown,
         ctrl.hd3_boost_mode}, 8'h00);
      $display("t_bank done");
   endtask
   task automatic t_swing();
      logic [7:0] c [7] = '{8'h00, 8'h09, 8'h0a, 8'h0d, 8'h0e, 8'h05, 8'hf9};
      logic [2:0] s [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h1};
      for (int i = 0; i < 7; i++) begin
         wr(12'h025, c[i]);
         chk_ctl({4'h0, illegal, ctrl.swing_sel}, {4'h0, 1'(i == 5), s[i]});
      end
      $display("t_swing done");
   endtask
   task automatic t_div();
      logic [2:0] r [4] = '{3'h1, 3'h1, 3'h2, 3'h4};
      for (int d = 0; d < 4; d++) begin
         wr(12'h027, {2'(d), 6'h00});
         chk_ctl({5'h0, ctrl.clk_div_ratio}, {5'h0, r[d]});
      end
      $display("t_div done");
   endtask
   task automatic t_pin();
      powerdown_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk_ctl({6'h0, ctrl.standby, ctrl.whole_device_powerdown}, 8'h01);
      wr(12'h015, 8'h01);
      chk_ctl({6'h0, ctrl.standby, ctrl.whole_device_powerdown}, 8'h02);
      powerdown_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk_ctl({6'h0, ctrl.standby, ctrl.whole_device_powerdown}, 8'h00);
      $display("t_pin done");
   endtask
   task automatic t_misc();
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b0, 12'h01d, 8'h00, q, e);
      chk_rd(q, 32'h0);
      chk_ctl({7'h0, e}, 8'h01);
      u_host.init();
      chk_ctl({5'h0, ctrl.chan_a_perf_special, ctrl.chan_b_perf_special,
         ctrl.sync_ref_buffer_off}, 8'h07);
      $display("t_misc done");
   endtask
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad("timeout");
         end_sim();
      end
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_bank();
      t_swing();
      t_div();
      t_pin();
      t_misc();
      end_sim();
   end
endmodule // tb_converter_config_registers
